// ==== tcm_cap_input.sv ====
// Register package and capture pin conditioner for the timer
`timescale 1ns/1ps
`default_nettype none
package tcm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NCH = 4;
	localparam int PINS_PER_CH = 2;
	localparam int CAP_PINS = NCH * PINS_PER_CH;
	localparam int MAT_PINS = NCH * PINS_PER_CH;
	// Register offsets
	localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] MODE_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] COUNT_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] PSTERM_OFF = 8'h0c;
	localparam logic [ADDR_W-1:0] PSCNT_OFF = 8'h10;
	localparam logic [ADDR_W-1:0] MATCTL_OFF = 8'h14;
	localparam logic [ADDR_W-1:0] CAPCTL_OFF = 8'h18;
	localparam logic [ADDR_W-1:0] EXTCTL_OFF = 8'h1c;
	localparam logic [ADDR_W-1:0] FLAGS_OFF = 8'h20;
	localparam logic [ADDR_W-1:0] PINSEL_OFF = 8'h24;
	localparam logic [ADDR_W-1:0] MATCH_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] CAPT_BASE = 8'h50;
	localparam logic [ADDR_W-1:0] BANK_MASK = 8'hf0;
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RST_BIT = 1;
	localparam int MODE_CNT_LSB = 0;
	localparam int MODE_SEL_LSB = 2;
	localparam int EXT_ACT_LSB = 4;
	localparam int PIN_AND_LSB = 8;
	localparam int PIN_MAT_LSB = 16;
	localparam int MC_IRQ = 0;
	localparam int MC_RST = 1;
	localparam int MC_STOP = 2;
	localparam int CC_RISE = 0;
	localparam int CC_FALL = 1;
	localparam int CC_IRQ = 2;
	localparam int CAP_FLAG_LSB = 4;
	// Counting modes
	localparam logic [1:0] MODE_TIMER = 2'h0;
	// External output actions
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// Reset values
	localparam logic [DATA_W-1:0] ZERO_W = 32'h0000_0000;
	localparam logic [7:0] PINEN_RST = 8'h55;
	localparam logic [7:0] MATPIN_RST = 8'h0f;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} tcm_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} tcm_axi_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} tcm_bus_st_t;
endpackage

// Synchronises a channel's pins, combines them and detects edges
module tcm_cap_input (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pins and selection
	input wire logic [tcm_pkg::PINS_PER_CH-1:0] pins,
	input wire logic [tcm_pkg::PINS_PER_CH-1:0] pinEn,
	input wire logic andMode,
	// Edge pulses
	output logic rise,
	output logic fall
);
	import tcm_pkg::*;

	logic [PINS_PER_CH-1:0] meta_r;
	logic [PINS_PER_CH-1:0] sync_r;
	logic comb_r;
	logic combNxt;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pins;
			sync_r <= meta_r;
		end
	end

	// OR or AND of the enabled pins
	always_comb begin
		if (andMode)
			combNxt = &(sync_r | ~pinEn) & (|pinEn); // R11
		else
			combNxt = |(sync_r & pinEn); // R11
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			comb_r <= 1'b0;
		else
			comb_r <= combNxt;
	end

	assign rise = combNxt & ~comb_r;
	assign fall = ~combNxt & comb_r;
endmodule
`default_nettype wire

// ==== tcm_timer.sv ====
// Timer/counter with prescaler, capture, match and AXI4-Lite registers
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - The count register and its prescaler are both 32 bits wide.
// R2 - Software picks timer mode on the clock or event counting mode.
// R3 - Event mode counts edges of one capture input, pulses lasting a clock.
// R4 - Other capture inputs keep capturing while one is the event source.
// R5 - Four 32-bit capture channels store the count on an edge, optional flag.
// R6 - Four 32-bit match registers are compared against the count.
// R7 - A match may leave the count running and optionally raise a flag.
// R8 - A match may stop the count and optionally raise a flag.
// R9 - A match may clear the count and optionally raise a flag.
// R10 - Each match drives an output low, high, toggled or unchanged.
// R11 - Capture pins combine by OR or AND and match outputs fan out to pins.
// R12 - The prescaler wraps at its terminal value and then bumps the count.
module tcm_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register bus
	input wire tcm_pkg::tcm_axi_req_t axiReq,
	output var tcm_pkg::tcm_axi_rsp_t axiRsp,
	// Capture and match pins
	input wire logic [tcm_pkg::CAP_PINS-1:0] capPins,
	output logic [tcm_pkg::MAT_PINS-1:0] matchPins,
	// Event request
	output logic irq
);
	import tcm_pkg::*;

	logic enable_r;
	logic ctrReset_r;
	logic [1:0] cntMode_r;
	logic [1:0] evSel_r;
	logic [DATA_W-1:0] tc_r;
	logic [DATA_W-1:0] pr_r;
	logic [DATA_W-1:0] pc_r;
	logic [DATA_W-1:0] match_r [NCH];
	logic [DATA_W-1:0] capt_r [NCH];
	logic [3*NCH-1:0] matCtl_r;
	logic [3*NCH-1:0] capCtl_r;
	logic [NCH-1:0] extOut_r;
	logic [2*NCH-1:0] extAct_r;
	logic [2*NCH-1:0] flags_r;
	logic [CAP_PINS-1:0] capPinEn_r;
	logic [NCH-1:0] capAnd_r;
	logic [MAT_PINS-1:0] matPinEn_r;
	logic [MAT_PINS-1:0] matchPins_r;

	logic [NCH-1:0] capRise;
	logic [NCH-1:0] capFall;
	logic [NCH-1:0] capHit;
	logic [NCH-1:0] matchHit;
	logic evEdge;
	logic countEn;
	logic tick;
	logic anyReset;
	logic anyStop;
	logic [2*NCH-1:0] flagSet;

	tcm_bus_st_t wrState_r;
	tcm_bus_st_t rdState_r;
	logic awHave_r;
	logic wHave_r;
	logic [ADDR_W-1:0] awAddr_r;
	logic [DATA_W-1:0] wData_r;
	logic [3:0] wStrb_r;
	logic [1:0] bresp_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic regWr;
	logic [DATA_W-1:0] rdWord;

	// Byte-lane merge of a write into an old value
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] nw, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				res[8*b+:8] = nw[8*b+:8];
		end
		return res;
	endfunction

	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic ok;
		ok = (a[1:0] == 2'h0) && ((a <= PINSEL_OFF) ||
			((a & BANK_MASK) == MATCH_BASE) || ((a & BANK_MASK) == CAPT_BASE));
		return ok;
	endfunction

	// Capture pin conditioning per channel
	generate
		for (genvar c = 0; c < NCH; c++) begin : gCap
			tcm_cap_input uIn (
				.ref_clk(ref_clk),
				.rstn(rstn),
				.pins(capPins[PINS_PER_CH*c+:PINS_PER_CH]),
				.pinEn(capPinEn_r[PINS_PER_CH*c+:PINS_PER_CH]),
				.andMode(capAnd_r[c]),
				.rise(capRise[c]),
				.fall(capFall[c])
			);
			assign capHit[c] = (capRise[c] & capCtl_r[3*c+CC_RISE]) |
				(capFall[c] & capCtl_r[3*c+CC_FALL]); // R4 R5
			assign matchHit[c] = tick && (tc_r == match_r[c]); // R6
		end
	endgenerate

	// Count source and prescale wrap
	assign evEdge = (cntMode_r[0] & capRise[evSel_r]) |
		(cntMode_r[1] & capFall[evSel_r]); // R3
	assign countEn = (cntMode_r == MODE_TIMER) ? 1'b1 : evEdge; // R2
	assign tick = enable_r && countEn && (pc_r == pr_r); // R12

	always_comb begin
		anyReset = 1'b0;
		anyStop = 1'b0;
		flagSet = '0;
		for (int i = 0; i < NCH; i++) begin
			anyReset = anyReset | (matchHit[i] & matCtl_r[3*i+MC_RST]); // R9
			anyStop = anyStop | (matchHit[i] & matCtl_r[3*i+MC_STOP]); // R8
			flagSet[i] = matchHit[i] & matCtl_r[3*i+MC_IRQ]; // R7
			flagSet[CAP_FLAG_LSB+i] = capHit[i] & capCtl_r[3*i+CC_IRQ]; // R5
		end
	end

	// Write channel
	assign regWr = awHave_r && wHave_r && (wrState_r == ST_IDLE);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrState_r <= ST_IDLE;
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= ZERO_W;
			wStrb_r <= 4'h0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (axiReq.awvalid && axiRsp.awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= axiReq.awaddr;
			end
			if (axiReq.wvalid && axiRsp.wready) begin
				wHave_r <= 1'b1;
				wData_r <= axiReq.wdata;
				wStrb_r <= axiReq.wstrb;
			end
			case (wrState_r)
				ST_IDLE: begin
					if (regWr) begin
						awHave_r <= 1'b0;
						wHave_r <= 1'b0;
						bresp_r <= mapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
						wrState_r <= ST_RESP;
					end
				end
				ST_RESP: begin
					if (axiReq.bready)
						wrState_r <= ST_IDLE;
				end
				default: wrState_r <= ST_IDLE;
			endcase
		end
	end

	// Read data selection
	always_comb begin
		rdWord = ZERO_W;
		case (axiReq.araddr & BANK_MASK)
			MATCH_BASE: rdWord = match_r[axiReq.araddr[3:2]];
			CAPT_BASE: rdWord = capt_r[axiReq.araddr[3:2]];
			default: begin
				case (axiReq.araddr)
					CTRL_OFF: rdWord[1:0] = {ctrReset_r, enable_r};
					MODE_OFF: rdWord[3:0] = {evSel_r, cntMode_r};
					COUNT_OFF: rdWord = tc_r;
					PSTERM_OFF: rdWord = pr_r;
					PSCNT_OFF: rdWord = pc_r;
					MATCTL_OFF: rdWord[3*NCH-1:0] = matCtl_r;
					CAPCTL_OFF: rdWord[3*NCH-1:0] = capCtl_r;
					EXTCTL_OFF: rdWord[11:0] = {extAct_r, extOut_r};
					FLAGS_OFF: rdWord[2*NCH-1:0] = flags_r;
					PINSEL_OFF: rdWord[23:0] = {matPinEn_r, 4'h0, capAnd_r,
						capPinEn_r};
					default: rdWord = ZERO_W;
				endcase
			end
		endcase
	end

	// Read channel
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdState_r <= ST_IDLE;
			rdata_r <= ZERO_W;
			rresp_r <= RESP_OKAY;
		end else begin
			case (rdState_r)
				ST_IDLE: begin
					if (axiReq.arvalid) begin
						rdata_r <= mapped(axiReq.araddr) ? rdWord :
							ZERO_W;
						rresp_r <= mapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
						rdState_r <= ST_RESP;
					end
				end
				ST_RESP: begin
					if (axiReq.rready)
						rdState_r <= ST_IDLE;
				end
				default: rdState_r <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		axiRsp.awready = !awHave_r && (wrState_r == ST_IDLE);
		axiRsp.wready = !wHave_r && (wrState_r == ST_IDLE);
		axiRsp.bvalid = (wrState_r == ST_RESP);
		axiRsp.bresp = bresp_r;
		axiRsp.arready = (rdState_r == ST_IDLE);
		axiRsp.rvalid = (rdState_r == ST_RESP);
		axiRsp.rdata = rdata_r;
		axiRsp.rresp = rresp_r;
	end

	// Control and configuration registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			enable_r <= 1'b0;
			ctrReset_r <= 1'b0;
			cntMode_r <= MODE_TIMER;
			evSel_r <= 2'h0;
			pr_r <= ZERO_W;
			matCtl_r <= '0;
			capCtl_r <= '0;
			extAct_r <= '0;
			capPinEn_r <= PINEN_RST;
			capAnd_r <= '0;
			matPinEn_r <= MATPIN_RST;
		end else begin
			if (anyStop)
				enable_r <= 1'b0; // R8
			if (regWr) begin
				case (awAddr_r)
					CTRL_OFF: if (wStrb_r[0]) begin
						enable_r <= wData_r[CTRL_EN_BIT];
						ctrReset_r <= wData_r[CTRL_RST_BIT];
					end
					MODE_OFF: if (wStrb_r[0]) begin
						cntMode_r <= wData_r[MODE_CNT_LSB+:2]; // R2
						evSel_r <= wData_r[MODE_SEL_LSB+:2]; // R3
					end
					PSTERM_OFF: pr_r <= merge(pr_r, wData_r, wStrb_r); // R1
					MATCTL_OFF: matCtl_r <= 12'(merge({20'h0, matCtl_r},
						wData_r, wStrb_r));
					CAPCTL_OFF: capCtl_r <= 12'(merge({20'h0, capCtl_r},
						wData_r, wStrb_r));
					EXTCTL_OFF: if (wStrb_r[0])
						extAct_r[3:0] <= wData_r[EXT_ACT_LSB+:4];
					PINSEL_OFF: begin
						if (wStrb_r[0])
							capPinEn_r <= wData_r[7:0]; // R11
						if (wStrb_r[1])
							capAnd_r <= wData_r[PIN_AND_LSB+:NCH]; // R11
						if (wStrb_r[2])
							matPinEn_r <= wData_r[PIN_MAT_LSB+:MAT_PINS]; // R11
					end
					default: ;
				endcase
				if (awAddr_r == EXTCTL_OFF && wStrb_r[1])
					extAct_r[7:4] <= wData_r[8+:4];
			end
		end
	end

	// Match value registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NCH; i++)
				match_r[i] <= ZERO_W;
		end else if (regWr && mapped(awAddr_r) &&
				(awAddr_r & BANK_MASK) == MATCH_BASE) begin
			match_r[awAddr_r[3:2]] <= merge(match_r[awAddr_r[3:2]], wData_r,
				wStrb_r); // R6
		end
	end

	// Prescale counter
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pc_r <= ZERO_W;
		else if (ctrReset_r)
			pc_r <= ZERO_W;
		else if (enable_r && countEn)
			pc_r <= (pc_r == pr_r) ? ZERO_W : pc_r + 32'h0000_0001; // R12
	end

	// Main counter
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			tc_r <= ZERO_W;
		else if (ctrReset_r)
			tc_r <= ZERO_W;
		else if (regWr && awAddr_r == COUNT_OFF)
			tc_r <= merge(tc_r, wData_r, wStrb_r);
		else if (tick)
			tc_r <= anyReset ? ZERO_W : tc_r + 32'h0000_0001; // R1 R9
	end

	// Capture registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NCH; i++)
				capt_r[i] <= ZERO_W;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (capHit[i])
					capt_r[i] <= tc_r; // R5
			end
		end
	end

	// Sticky flags, set wins over write-one clear
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			flags_r <= '0;
		else if (regWr && awAddr_r == FLAGS_OFF && wStrb_r[0])
			flags_r <= (flags_r & ~wData_r[2*NCH-1:0]) | flagSet;
		else
			flags_r <= flags_r | flagSet; // R7
	end

	assign irq = |flags_r;

	// External match outputs
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			extOut_r <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (matchHit[i]) begin
					case (extAct_r[2*i+:2])
						ACT_LOW: extOut_r[i] <= 1'b0; // R10
						ACT_HIGH: extOut_r[i] <= 1'b1; // R10
						ACT_TOGGLE: extOut_r[i] <= ~extOut_r[i]; // R10
						default: ;
					endcase
				end else if (regWr && awAddr_r == EXTCTL_OFF && wStrb_r[0]) begin
					extOut_r[i] <= wData_r[i];
				end
			end
		end
	end

	// Broadcast of each output to its pins
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			matchPins_r <= '0;
		end else begin
			for (int j = 0; j < MAT_PINS; j++)
				matchPins_r[j] <= matPinEn_r[j] & extOut_r[j % NCH]; // R11
		end
	end

	assign matchPins = matchPins_r;
endmodule
`default_nettype wire

// ==== tcm_pin_model.sv ====
// Capture pin driver standing in for the world outside the timer
`timescale 1ns/1ps
`default_nettype none
module tcm_pin_model (
	// Clock
	input wire logic ref_clk,
	// Pins
	output logic [tcm_pkg::CAP_PINS-1:0] capPins,
	input wire logic [tcm_pkg::MAT_PINS-1:0] matchPins
);
	import tcm_pkg::*;
	initial capPins = 8'h00;
	// Pulse the masked pins, several clocks high and low
	task automatic pulse(input logic [CAP_PINS-1:0] m);
		@(posedge ref_clk);
		capPins <= capPins | m;
		repeat (3) @(posedge ref_clk);
		capPins <= capPins & ~m;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== tcm_timer_properties.sv ====
// Concurrent checks on the timer's register bus
`timescale 1ns/1ps
`default_nettype none
module tcm_timer_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register bus
	input wire tcm_pkg::tcm_axi_req_t axiReq,
	input wire tcm_pkg::tcm_axi_rsp_t axiRsp,
	// Pins
	input wire logic [tcm_pkg::CAP_PINS-1:0] capPins,
	input wire logic [tcm_pkg::MAT_PINS-1:0] matchPins,
	input wire logic irq
);
	import tcm_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_bHold;
		axiRsp.bvalid && !axiReq.bready |=>
			axiRsp.bvalid && $stable(axiRsp.bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("bvalid dropped");
	property p_bDone;
		axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid;
	endproperty
	a_bDone: assert property (p_bDone) else $error("bvalid stuck");
	property p_wAns;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
			|=> !axiRsp.awready ##1 axiRsp.bvalid;
	endproperty
	a_wAns: assert property (p_wAns) else $error("write answer late");
	property p_rAns;
		axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready;
	endproperty
	a_rAns: assert property (p_rAns) else $error("read answer late");
	property p_rHold;
		axiRsp.rvalid && !axiReq.rready |=>
			axiRsp.rvalid && $stable(axiRsp.rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("rdata moved");
	property p_rDone;
		axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid;
	endproperty
	a_rDone: assert property (p_rDone) else $error("rvalid stuck");
	property p_busy;
		axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready;
	endproperty
	a_busy: assert property (p_busy) else $error("write taken early");
	property p_hole;
		axiReq.arvalid && axiRsp.arready && axiReq.araddr == 8'h30 |=>
			axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == ZERO_W;
	endproperty
	a_hole: assert property (p_hole) else $error("hole read");
	c_write: cover property (axiRsp.bvalid && axiReq.bready);
	c_read: cover property (axiRsp.rvalid && axiReq.rready);
	c_irq: cover property ($rose(irq));
	c_pins: cover property (matchPins != 8'h00 && capPins != 8'h00);
endmodule
bind tcm_timer tcm_timer_properties i_props (.ref_clk(ref_clk),
	.rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp), .capPins(capPins),
	.matchPins(matchPins), .irq(irq));
`default_nettype wire

// ==== test_timer_capture_match_unit.sv ====
// Self-checking bench for the timer over its register bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_timer_capture_match_unit;
	import tcm_pkg::*;
	logic ref_clk;
	logic rstn;
	tcm_axi_req_t req;
	tcm_axi_rsp_t rsp;
	logic [CAP_PINS-1:0] capPins;
	logic [MAT_PINS-1:0] matchPins;
	logic irq;
	int errors;
	int samplesChecked;
	logic [31:0] v;
	logic [31:0] mx;
	logic [1:0] r;
	int wt;

	tcm_timer i_dut (.ref_clk(ref_clk), .rstn(rstn), .axiReq(req),
		.axiRsp(rsp), .capPins(capPins), .matchPins(matchPins), .irq(irq));
	tcm_pin_model i_pins (.ref_clk(ref_clk), .capPins(capPins),
		.matchPins(matchPins));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic tick(inout int n);
		n++;
		if (n > 50) begin
			errors++;
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hf);
		int n;
		logic aw, w, b;
		n = 0;
		b = 1'b0;
		@(posedge ref_clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!b) begin
			@(negedge ref_clk);
			aw = rsp.awready;
			w = rsp.wready;
			b = rsp.bvalid;
			r = rsp.bresp;
			@(posedge ref_clk);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
			if (b) req.bready <= 1'b0;
			tick(n);
		end
		`CHK("bresp", er, r)
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		logic ar, rv;
		n = 0;
		rv = 1'b0;
		@(posedge ref_clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		while (!rv) begin
			@(negedge ref_clk);
			ar = rsp.arready;
			rv = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge ref_clk);
			if (ar) req.arvalid <= 1'b0;
			if (rv) req.rready <= 1'b0;
			tick(n);
		end
	endtask

	task automatic ck(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		rd(a, v);
		`CHK(nm, e, v)
		`CHK("rresp", er, r)
	endtask

	initial begin
		rstn = 1'b0;
		req = '0;
		errors = 0;
		samplesChecked = 0;
		mx = ZERO_W;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		ck("pinsel", PINSEL_OFF, 32'h000f0055);
		ck("psterm", PSTERM_OFF, ZERO_W);
		ck("ctrl", CTRL_OFF, ZERO_W);
		ck("hole", 8'h30, ZERO_W, RESP_SLVERR);
		wr(8'hb0, 32'hffff_ffff, RESP_SLVERR);
		wr(8'h45, 32'hffff_ffff, RESP_SLVERR);
		ck("unaligned", 8'h45, ZERO_W, RESP_SLVERR);
		ck("match1", MATCH_BASE + 8'h4, ZERO_W);
		ck("high", 8'hc0, ZERO_W, RESP_SLVERR);
		wr(PSTERM_OFF, 32'hffff_ffff, RESP_OKAY, 4'ha);
		ck("psterm lanes", PSTERM_OFF, 32'hff00_ff00);
		wr(PSTERM_OFF, ZERO_W);
		$display("test reset done");
		for (int i = 0; i < NCH; i++) wr(MATCH_BASE + 8'(4 * i), 32'h5);
		wr(EXTCTL_OFF, 32'h395);
		wr(PINSEL_OFF, 32'h00ff0055);
		wr(MATCTL_OFF, 32'h5);
		wr(CTRL_OFF, 32'h1);
		wt = 0;
		while (irq !== 1'b1) begin
			@(posedge ref_clk);
			tick(wt);
		end
		ck("ctrl", CTRL_OFF, ZERO_W);
		ck("count", COUNT_OFF, 32'h6);
		ck("count", COUNT_OFF, 32'h6);
		`CHK("matchPins", 8'h22, matchPins)
		`CHK("irq", 1'b1, irq)
		ck("flags", FLAGS_OFF, 32'h1);
		wr(CAPCTL_OFF, 32'h28);
		i_pins.pulse(8'h04);
		ck("capt1", CAPT_BASE + 8'h4, 32'h6);
		ck("flags", FLAGS_OFF, 32'h21);
		wr(FLAGS_OFF, 32'hff);
		@(negedge ref_clk);
		`CHK("irq", 1'b0, irq)
		@(posedge ref_clk);
		$display("test stop done");
		wr(PSTERM_OFF, 32'h2);
		wr(MATCTL_OFF, 32'h10);
		wr(MATCH_BASE + 8'h4, 32'h2);
		wr(COUNT_OFF, ZERO_W);
		wr(CTRL_OFF, 32'h1);
		for (int i = 0; i < 12; i++) begin
			rd(COUNT_OFF, v);
			if (v > mx) mx = v;
		end
		`CHK("count peak", 32'h2, mx)
		wr(CTRL_OFF, ZERO_W);
		rd(PSCNT_OFF, v);
		`CHK("prescale", 1'b1, v <= 32'h2)
		$display("test reload done");
		wr(MATCTL_OFF, ZERO_W);
		wr(PSTERM_OFF, ZERO_W);
		for (int m = 1; m < 4; m++) begin
			wr(CTRL_OFF, 32'h2);
			wr(MODE_OFF, 32'(m));
			wr(CTRL_OFF, 32'h1);
			i_pins.pulse(8'h01);
			ck("events", COUNT_OFF, (m == 3) ? 32'h2 : 32'h1);
		end
		wr(CTRL_OFF, 32'h2);
		wr(MODE_OFF, 32'h1);
		wr(CTRL_OFF, 32'h1);
		for (int i = 0; i < 3; i++) i_pins.pulse(8'h01);
		i_pins.pulse(8'h04);
		i_pins.pulse(8'h01);
		ck("events", COUNT_OFF, 32'h4);
		ck("capt1", CAPT_BASE + 8'h4, 32'h3);
		wr(CTRL_OFF, ZERO_W);
		$display("test events done");
		wr(FLAGS_OFF, 32'hff);
		wr(PINSEL_OFF, 32'h00ff04f5);
		wr(CAPCTL_OFF, 32'hb40);
		i_pins.pulse(8'h10);
		ck("and one", FLAGS_OFF, ZERO_W);
		i_pins.pulse(8'h30);
		ck("and both", FLAGS_OFF, 32'h40);
		ck("capt2", CAPT_BASE + 8'h8, 32'h4);
		i_pins.pulse(8'h8a);
		ck("or one", FLAGS_OFF, 32'hc0);
		ck("capt3", CAPT_BASE + 8'hc, 32'h4);
		$display("test combine done");
		summarize();
	end
endmodule
`default_nettype wire
